// ### pkg/bus_mode_cfg.svh
`ifndef BUS_MODE_CFG_SVH
`define BUS_MODE_CFG_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define CFG_CORE_PERIOD_NS 10
// Pattern hold margin after RST# rises, least time
`define CFG_HOLD_NS        40
// Longest wait for PLL lock before giving up
`define CFG_LOCK_NS        100000

// ----------------------------------------
// Secondary clock divider codes
// ----------------------------------------
`define CFG_DIV_CONV33     2'h0
`define CFG_DIV_CONV66     2'h1
`define CFG_DIV_X100       2'h2
`define CFG_DIV_X133       2'h3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CFG_RST_DIV        2'h0
`define CFG_RST_CNT        16'h0000

`endif

// ### pkg/bus_mode_pkg.sv
package bus_mode_pkg;

  // ----------------------------------------
  // Clock range told by the init pattern
  // ----------------------------------------
  typedef enum logic [2:0] {
    RANGE_CONV33,
    RANGE_CONV66,
    RANGE_X66,
    RANGE_X100,
    RANGE_X133,
    RANGE_RSVD
  } clk_range_t;

  // Values held by the mode latch
  typedef struct packed {
    logic       pcix;
    logic       m66;
    logic       rsvd;
    clk_range_t range;
  } mode_t;

  typedef enum logic [1:0] {
    ST_HOLD,
    ST_SETTLE,
    ST_LOCK,
    ST_RUN
  } seq_state_t;

  typedef logic [15:0] cnt_t;

  typedef struct packed {
    seq_state_t st;
    cnt_t       cnt;
    logic       lock_err;
    logic       pll_en;
    logic       devsel_fast;
    logic [1:0] sec_div;
    logic       devsel_n;
    logic       stop_n;
    logic       trdy_n;
    logic       bus_idle;
  } seq_t;

endpackage : bus_mode_pkg

// ### src/init_pattern_decode.sv
`timescale 1ns/1ps
`default_nettype none

module init_pattern_decode (
  input  wire logic              frame_n,
  input  wire logic              irdy_n,
  input  wire logic              devsel_n,
  input  wire logic              stop_n,
  input  wire logic              trdy_n,
  input  wire logic              m66en,
  output var  bus_mode_pkg::mode_t pattern
);
  import bus_mode_pkg::*;

  always_comb begin
    pattern       = '0;
    // Idle bus with any target signal low selects the fast protocol
    pattern.pcix  = frame_n && irdy_n && !(devsel_n && stop_n && trdy_n);
    pattern.m66   = !pattern.pcix && m66en;
    pattern.rsvd  = pattern.pcix && !devsel_n;
    if (!pattern.pcix) begin
      pattern.range = m66en ? RANGE_CONV66 : RANGE_CONV33;
    end else if (!devsel_n) begin
      pattern.range = RANGE_RSVD;
    end else if (!stop_n && !trdy_n) begin
      pattern.range = RANGE_X133;
    end else if (!stop_n) begin
      pattern.range = RANGE_X100;
    end else begin
      pattern.range = RANGE_X66;
    end
  end

endmodule : init_pattern_decode

`default_nettype wire

// ### src/mode_latch.sv
`timescale 1ns/1ps
`default_nettype none

module mode_latch (
  input  wire logic                sys_rst,
  input  wire logic                bus_rst_n,
  input  var  bus_mode_pkg::mode_t pattern,
  output var  bus_mode_pkg::mode_t mode
);
  import bus_mode_pkg::*;

  // ----------------------------------------
  // Clockless capture
  // ----------------------------------------
  // The bus clock may stop or change while RST# is low, so the mode is
  // held by a level latch rather than a flop; it closes as RST# rises.
  always_latch begin
    if (sys_rst) begin
      mode <= '0;
    end else if (!bus_rst_n) begin
      mode <= pattern;
    end
  end

endmodule : mode_latch

`default_nettype wire

// ### src/bus_mode_init.sv
`timescale 1ns/1ps
`default_nettype none

`include "bus_mode_cfg.svh"

// Operation
// - Protocol choice comes only from pattern seen as RST# rises.
// - State machines, PLL range, buffers all follow that sampled pattern.
// - During reset the mode may follow the pattern combinationally.
// - During reset hold state machines reset and force PLL relock.
// - Mode capture needs no bus clock; latch closes on RST# rise.
// - Latched mode switches bus buffers and interface logic to fast protocol.
// - Fast mode tunes options from range; conventional uses M66EN.
// - Bridge may pick secondary clock divider from decoded range.
// - State machines ignore target signals while FRAME# and IRDY# high.
// - Already running device ignores pattern meant for a new card.
// - PLL off in conventional 33; on only in fast or conventional 66.
// - Fast mode and conventional 66 are detected separately for PLL.
// - External PLL is enabled through a mode output pin.
// - Fast mode: FRAME#, IRDY# high and some target signal low.
// - TRDY# 50-66, STOP# 66-100, both 100-133; DEVSEL# low reserved.
module bus_mode_init #(
  parameter int LOCK_CYCLES = `CFG_LOCK_NS / `CFG_CORE_PERIOD_NS
) (
  input  wire logic                    core_clk,
  input  wire logic                    sys_rst,
  input  wire logic                    bus_rst_n,
  input  wire logic                    frame_n,
  input  wire logic                    irdy_n,
  input  wire logic                    devsel_n,
  input  wire logic                    stop_n,
  input  wire logic                    trdy_n,
  input  wire logic                    m66en,
  input  wire logic                    pll_locked,
  output logic                         pcix_mode_pin,
  output logic                         io_pcix_sel,
  output var  bus_mode_pkg::clk_range_t clk_range,
  output logic                         rsvd_pattern,
  output logic                         pll_rst,
  output logic                         pll_en,
  output logic                         sm_rst,
  output logic                         link_ready,
  output logic                         lock_err,
  output logic                         devsel_fast,
  output logic [1:0]                   sec_div,
  output logic                         tgt_devsel_n,
  output logic                         tgt_stop_n,
  output logic                         tgt_trdy_n,
  output logic                         bus_idle
);
  import bus_mode_pkg::*;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int   HOLD_CYC   = (`CFG_HOLD_NS + `CFG_CORE_PERIOD_NS - 1) / `CFG_CORE_PERIOD_NS;
  localparam cnt_t HOLD_LAST  = cnt_t'(HOLD_CYC - 1);
  localparam cnt_t LOCK_LAST  = cnt_t'(LOCK_CYCLES - 1);

  // ----------------------------------------
  // Pattern decode and clockless capture
  // ----------------------------------------
  mode_t pattern;
  mode_t mode;

  init_pattern_decode u_decode (
    .frame_n  (frame_n),
    .irdy_n   (irdy_n),
    .devsel_n (devsel_n),
    .stop_n   (stop_n),
    .trdy_n   (trdy_n),
    .m66en    (m66en),
    .pattern  (pattern)
  );

  // Latch is closed whenever RST# is high, so later patterns on the bus,
  // such as one aimed at a hot-inserted card, cannot reach it.
  mode_latch u_latch (
    .sys_rst   (sys_rst),
    .bus_rst_n (bus_rst_n),
    .pattern   (pattern),
    .mode      (mode)
  );

  // ----------------------------------------
  // Frequency-dependent options
  // ----------------------------------------
  function automatic logic [1:0] div_for(input clk_range_t r);
    case (r)
      RANGE_CONV66: div_for = `CFG_DIV_CONV66;
      RANGE_X66:    div_for = `CFG_DIV_CONV66;
      RANGE_X100:   div_for = `CFG_DIV_X100;
      RANGE_X133:   div_for = `CFG_DIV_X133;
      default:      div_for = `CFG_DIV_CONV33;
    endcase
  endfunction : div_for

  // Fast decode only pays off at the top ranges; slow clocks keep margin
  function automatic logic fast_decode(input clk_range_t r);
    fast_decode = (r == RANGE_X100) || (r == RANGE_X133);
  endfunction : fast_decode

  // PLL may run only in the fast protocol or conventional 66
  function automatic logic pll_allowed(input mode_t m);
    pll_allowed = m.pcix || m.m66;
  endfunction : pll_allowed

  // ----------------------------------------
  // Sequencer state
  // ----------------------------------------
  seq_t s_q;
  seq_t s_d;

  logic idle_now;

  assign idle_now = frame_n && irdy_n;

  always_comb begin
    s_d          = s_q;
    s_d.bus_idle = idle_now;
    // Target signals seen on an idle bus are a pattern, not a transaction
    s_d.devsel_n = idle_now ? 1'b1 : devsel_n;
    s_d.stop_n   = idle_now ? 1'b1 : stop_n;
    s_d.trdy_n   = idle_now ? 1'b1 : trdy_n;
    if (!bus_rst_n) begin
      // Clock may change here, so drop everything and relock later
      s_d.st          = ST_HOLD;
      s_d.cnt         = `CFG_RST_CNT;
      s_d.lock_err    = 1'b0;
      s_d.pll_en      = 1'b0;
      s_d.devsel_fast = 1'b0;
      s_d.sec_div     = `CFG_RST_DIV;
    end else begin
      case (s_q.st)
        ST_HOLD: begin
          s_d.st  = ST_SETTLE;
          s_d.cnt = `CFG_RST_CNT;
        end
        ST_SETTLE: begin
          // Wait out the hold margin before trusting the latched mode
          if (s_q.cnt >= HOLD_LAST) begin
            s_d.cnt         = `CFG_RST_CNT;
            s_d.pll_en      = pll_allowed(mode);
            s_d.devsel_fast = mode.pcix ? fast_decode(mode.range) : mode.m66;
            s_d.sec_div     = div_for(mode.range);
            s_d.st          = pll_allowed(mode) ? ST_LOCK : ST_RUN;
          end else begin
            s_d.cnt = s_q.cnt + 16'h0001;
          end
        end
        ST_LOCK: begin
          if (pll_locked) begin
            s_d.st = ST_RUN;
          end else if (s_q.cnt >= LOCK_LAST) begin
            // Give up waiting but let software see the failure
            s_d.lock_err = 1'b1;
            s_d.st       = ST_RUN;
          end else begin
            s_d.cnt = s_q.cnt + 16'h0001;
          end
        end
        ST_RUN: begin
          s_d.st = ST_RUN;
        end
        default: begin
          s_d.st = ST_HOLD;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q             <= '0;
      s_q.st          <= ST_HOLD;
      s_q.cnt         <= `CFG_RST_CNT;
      s_q.sec_div     <= `CFG_RST_DIV;
      s_q.devsel_n    <= 1'b1;
      s_q.stop_n      <= 1'b1;
      s_q.trdy_n      <= 1'b1;
      s_q.bus_idle    <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Mode pins come straight from the latch so they follow the pattern
  // during reset and never wait for a clock that may not be running.
  assign pcix_mode_pin = mode.pcix;
  assign io_pcix_sel   = mode.pcix;
  assign clk_range     = mode.range;
  assign rsvd_pattern  = mode.rsvd;

  assign pll_rst       = !bus_rst_n;
  // Interface logic stays in reset until the clock is trusted
  assign sm_rst        = !bus_rst_n || (s_q.st != ST_RUN);
  assign link_ready    = (s_q.st == ST_RUN);
  assign pll_en        = s_q.pll_en;
  assign lock_err      = s_q.lock_err;
  assign devsel_fast   = s_q.devsel_fast;
  assign sec_div       = s_q.sec_div;
  assign tgt_devsel_n  = s_q.devsel_n;
  assign tgt_stop_n    = s_q.stop_n;
  assign tgt_trdy_n    = s_q.trdy_n;
  assign bus_idle      = s_q.bus_idle;

endmodule : bus_mode_init

`default_nettype wire

// ### tb/bus_mode_init_chk.sv
`timescale 1ns/1ps
`default_nettype none

module bus_mode_init_chk #(
  parameter int LOCK_CYCLES = 20
) (
  input wire logic                    core_clk,
  input wire logic                    sys_rst,
  input wire logic                    bus_rst_n,
  input wire logic                    frame_n,
  input wire logic                    irdy_n,
  input wire logic                    stop_n,
  input wire logic                    pcix_mode_pin,
  input wire logic                    io_pcix_sel,
  input var  bus_mode_pkg::clk_range_t clk_range,
  input wire logic                    pll_rst,
  input wire logic                    pll_en,
  input wire logic                    sm_rst,
  input wire logic                    link_ready,
  input wire logic                    devsel_fast,
  input wire logic [1:0]              sec_div,
  input wire logic                    tgt_stop_n
);
  import bus_mode_pkg::*;
  // Lock wait plus settle slack
  localparam int LOCK_LIM = LOCK_CYCLES + 4;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_pll_rst_follow: assert property (pll_rst == !bus_rst_n)
    else $error("pll reset not tied to bus reset");
  a_sm_held: assert property (!bus_rst_n |-> sm_rst ##1 !link_ready)
    else $error("state machines run during bus reset");
  a_pll_off_33: assert property (bus_rst_n && !pcix_mode_pin && clk_range == RANGE_CONV33 |-> !pll_en)
    else $error("pll enabled in slow conventional mode");
  a_pll_cause: assert property ($rose(pll_en) |-> pcix_mode_pin || clk_range == RANGE_CONV66)
    else $error("pll enabled without cause");
  a_mode_held: assert property (bus_rst_n && $past(bus_rst_n) |-> $stable(pcix_mode_pin) && $stable(clk_range))
    else $error("latched mode moved after release");
  a_io_sel_same: assert property (io_pcix_sel == pcix_mode_pin)
    else $error("buffer select differs from mode");
  a_idle_mask: assert property ($past(frame_n && irdy_n) |-> tgt_stop_n)
    else $error("target signal passed on idle bus");
  a_tgt_pass: assert property (!$past(frame_n && irdy_n) |-> tgt_stop_n == $past(stop_n))
    else $error("target signal lost on busy bus");
  a_lock_bound: assert property ($rose(pll_en) |-> ##[0:LOCK_LIM] link_ready)
    else $error("lock wait not bounded");
  a_settle_time: assert property ($rose(bus_rst_n) |-> ##[4:10] (pll_en || link_ready))
    else $error("sequencer did not leave settle");
  a_div_fast: assert property (bus_rst_n && link_ready |-> (sec_div == 2'h3) == (clk_range == RANGE_X133))
    else $error("divider does not match range");
  a_devsel_tune: assert property (bus_rst_n && link_ready |->
    devsel_fast == (pcix_mode_pin ? clk_range inside {RANGE_X100, RANGE_X133} : clk_range == RANGE_CONV66))
    else $error("decode timing does not match range");

  c_pcix_run: cover property (link_ready && pcix_mode_pin);
  c_conv66: cover property (link_ready && clk_range == RANGE_CONV66);
  c_lock_wait: cover property ($rose(pll_en) ##[1:LOCK_LIM] link_ready);
endmodule : bus_mode_init_chk

bind bus_mode_init bus_mode_init_chk #(.LOCK_CYCLES(LOCK_CYCLES)) chk (.core_clk, .sys_rst, .bus_rst_n, .frame_n,
  .irdy_n, .stop_n, .pcix_mode_pin, .io_pcix_sel, .clk_range, .pll_rst, .pll_en, .sm_rst, .link_ready,
  .devsel_fast, .sec_div, .tgt_stop_n);

`default_nettype wire

// ### tb/reset_source.sv
`timescale 1ns/1ps
`default_nettype none

module reset_source (
  input  wire logic core_clk,
  output logic      bus_rst_n,
  output logic      frame_n,
  output logic      irdy_n,
  output logic      devsel_n,
  output logic      stop_n,
  output logic      trdy_n,
  output logic      m66en
);
  // Floated pattern lines read high through the pull-ups
  initial begin
    bus_rst_n = 1'b0;
    {frame_n, irdy_n, devsel_n, stop_n, trdy_n} = 5'h1f;
    m66en = 1'b0;
  end

  // Every reset reapplies a pattern; clock never retuned here
  task automatic assert_rst(input logic [5:0] p);
    @(posedge core_clk);
    bus_rst_n <= 1'b0;
    {frame_n, irdy_n, devsel_n, stop_n, trdy_n, m66en} <= p;
  endtask : assert_rst

  // Pattern held 4 cycles past the rise for the latch hold margin
  task automatic release_rst;
    repeat (4) @(posedge core_clk);
    bus_rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    {frame_n, irdy_n, devsel_n, stop_n, trdy_n} <= 5'h1f;
  endtask : release_rst

  // Capability pin as sensed: 2'b00 grounded, 2'b01 pulled down, 2'b10 open.
  // Only legal patterns come out; reserved codes are never produced.
  function automatic logic [5:0] pick_pattern(input logic [1:0] cap, input logic card_m66);
    case (cap)
      2'b10:   pick_pattern = 6'b111000;
      2'b01:   pick_pattern = 6'b111100;
      default: pick_pattern = {5'h1f, card_m66};
    endcase
  endfunction : pick_pattern

  // A slot joins only if its card takes the running mode and clock
  function automatic logic can_join(input logic [1:0] cap, input logic [5:0] bus_pat);
    logic fast;
    fast     = bus_pat[5] & bus_pat[4] & ~&bus_pat[3:1];
    can_join = !(fast && (cap == 2'b00)) && !(fast && (cap == 2'b01) && !bus_pat[2]);
  endfunction : can_join

  // One cycle of traffic, as a hot-plug pattern would appear
  task automatic drive_bus(input logic [4:0] b);
    @(posedge core_clk);
    {frame_n, irdy_n, devsel_n, stop_n, trdy_n} <= b;
    @(posedge core_clk);
    {frame_n, irdy_n, devsel_n, stop_n, trdy_n} <= 5'h1f;
  endtask : drive_bus
endmodule : reset_source

`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
  import bus_mode_pkg::*;
  logic       core_clk, sys_rst, pll_locked, bus_rst_n, frame_n, irdy_n, devsel_n, stop_n, trdy_n, m66en;
  logic       pcix_mode_pin, io_pcix_sel, rsvd_pattern, pll_rst, pll_en, sm_rst, link_ready, lock_err;
  logic       devsel_fast, tgt_devsel_n, tgt_stop_n, tgt_trdy_n, bus_idle;
  logic [1:0] sec_div;
  clk_range_t clk_range;
  int         n_mismatch = 0;
  int         num_checks = 0;
  int         cyc = 0;

  bus_mode_init #(.LOCK_CYCLES(20)) uut (.core_clk, .sys_rst, .bus_rst_n, .frame_n, .irdy_n, .devsel_n,
    .stop_n, .trdy_n, .m66en, .pll_locked, .pcix_mode_pin, .io_pcix_sel, .clk_range, .rsvd_pattern,
    .pll_rst, .pll_en, .sm_rst, .link_ready, .lock_err, .devsel_fast, .sec_div, .tgt_devsel_n,
    .tgt_stop_n, .tgt_trdy_n, .bus_idle);
  reset_source src (.core_clk, .bus_rst_n, .frame_n, .irdy_n, .devsel_n, .stop_n, .trdy_n, .m66en);

  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  // Whole run needs about 860 cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  task automatic check(input logic [2:0] got, input logic [2:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check

  task automatic wait_ready;
    for (int k = 0; k < 100 && link_ready !== 1'b1; k++)
      @(posedge core_clk);
    @(negedge core_clk);
    check(link_ready, 1'b1);
  endtask : wait_ready

  // Pattern bits are frame, irdy, devsel, stop, trdy, m66en
  function automatic clk_range_t exp_rng(input logic [5:0] p);
    if (!(p[5] & p[4] & ~&p[3:1]))
      return p[0] ? RANGE_CONV66 : RANGE_CONV33;
    if (!p[3])
      return RANGE_RSVD;
    return (p[2:1] == 2'b10) ? RANGE_X66 : (p[2:1] == 2'b01) ? RANGE_X100 : RANGE_X133;
  endfunction : exp_rng

  task automatic t_modes;
    logic       pcix;
    clk_range_t r;
    logic [1:0] d;
    for (int i = 0; i < 64; i++) begin
      src.assert_rst(i[5:0]);
      src.release_rst();
      wait_ready();
      pcix = i[5] & i[4] & ~&i[3:1];
      r = exp_rng(i[5:0]);
      d = (r == RANGE_X133) ? 2'h3 : (r == RANGE_X100) ? 2'h2 : (r inside {RANGE_CONV66, RANGE_X66}) ? 2'h1 : 2'h0;
      check(pcix_mode_pin, pcix);
      check(clk_range, r);
      check(rsvd_pattern, pcix & ~i[3]);
      check(pll_en, pcix | i[0]);
      check(sec_div, d);
      check(devsel_fast, pcix ? r inside {RANGE_X100, RANGE_X133} : i[0]);
      check(sm_rst, 1'b0);
    end
    $display("test modes done");
  endtask : t_modes

  task automatic t_transp;
    src.assert_rst(6'b111100);
    @(negedge core_clk);
    check(clk_range, RANGE_X66);
    check(pll_rst, 1'b1);
    src.assert_rst(6'b111010);
    @(negedge core_clk);
    check(clk_range, RANGE_X100);
    check({sm_rst, pll_en}, 3'h2);
    src.release_rst();
    wait_ready();
    $display("test transparent done");
  endtask : t_transp

  task automatic t_hold;
    src.drive_bus(5'b11000);
    @(negedge core_clk);
    check({tgt_devsel_n, tgt_stop_n, tgt_trdy_n}, 3'h7);
    check(clk_range, RANGE_X100);
    src.drive_bus(5'b01110);
    @(negedge core_clk);
    check({tgt_devsel_n, tgt_stop_n, tgt_trdy_n}, 3'h6);
    $display("test hold done");
  endtask : t_hold

  // Hot-plug bring-up: conventional 33 first, then retune to the cards found
  task automatic t_bringup;
    logic [5:0] p;
    src.assert_rst(src.pick_pattern(2'b00, 1'b0));
    src.release_rst();
    wait_ready();
    check(clk_range, RANGE_CONV33);
    check(pll_en, 1'b0);
    p = src.pick_pattern(2'b10, 1'b0);
    src.assert_rst(p);
    src.release_rst();
    wait_ready();
    check(clk_range, RANGE_X133);
    check(src.can_join(2'b01, p), 1'b0);
    if (src.can_join(2'b10, p))
      src.drive_bus(p[5:1]);
    @(negedge core_clk);
    check(clk_range, RANGE_X133);
    check(bus_idle, 1'b1);
    $display("test bring-up done");
  endtask : t_bringup

  // Mid-run system reset clears the latch even with RST# high
  task automatic t_sysrst;
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    check(clk_range, RANGE_CONV33);
    check({link_ready, bus_idle, tgt_devsel_n}, 3'h3);
    @(posedge core_clk);
    sys_rst <= 1'b0;
    wait_ready();
    check(pll_en, 1'b0);
    $display("test system reset done");
  endtask : t_sysrst

  task automatic t_timeout;
    @(posedge core_clk);
    pll_locked <= 1'b0;
    src.assert_rst(6'b111000);
    src.release_rst();
    wait_ready();
    check({lock_err, pll_en}, 3'h3);
    @(posedge core_clk);
    pll_locked <= 1'b1;
    src.assert_rst(6'b111000);
    @(posedge core_clk);
    @(negedge core_clk);
    check(lock_err, 1'b0);
    src.release_rst();
    wait_ready();
    check(lock_err, 1'b0);
    $display("test lock timeout done");
  endtask : t_timeout

  initial begin
    sys_rst = 1'b1;
    pll_locked = 1'b1;
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_modes();
    t_transp();
    t_hold();
    t_bringup();
    t_sysrst();
    t_timeout();
    finish_test();
  end
endmodule : tb

`default_nettype wire
